// ==== rtl/uic_ctrl.sv ====
// Host register, queue control and prioritised interrupt identification for the serial port
// Function
// (RQ1) Offset zero write loads holding, shifter reloads later
// (RQ2) Enable register low four bits, upper read zero
// (RQ3) Enable bit zero: received data and timeout
// (RQ4) Enable bit one: holding register empty
// (RQ5) Enable bit two: receiver line status errors
// (RQ6) Enable bit three: modem status change
// (RQ7) Queue control write-only, shares offset two
// (RQ8) Queue control bit zero enables; clearing empties queues
// (RQ9) Software keeps bit zero set programming others
// (RQ10) Bit one empties receive queue, self-clearing
// (RQ11) Bit two empties transmit queue, self-clearing
// (RQ12) Bit three no effect; four, five reserved
// (RQ13) Bits seven, six pick trigger 1/4/8/14
// (RQ14) Priority: line, data, holding empty, modem
// (RQ15) Identification frozen while host reads it
// (RQ16) Identification bit zero low when pending
// (RQ17) Bits two, one encode top source
// (RQ18) Bit three marks timeout in queue mode
// (RQ19) Bits seven, six show queue mode
// (RQ20) Timeout after four silent character times
// (RQ21) Holding empty clears on ident read, write
// (RQ22) Line, data, modem clear by their reads
// (RQ23) Line format bit seven selects divisor latch
// (RQ24) Interrupt output gated by output-two bit
`timescale 1ns/10ps
`default_nettype none

module uic_ctrl
  import uic_pkg::*;
#(
  parameter int LVL_W = 5
)
(
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [2:0]       host_addr,
  input  wire logic             host_wr,
  input  wire logic             host_rd,
  input  wire logic [7:0]       host_wdata,
  output logic      [7:0]       host_rdata,
  input  wire logic             tx_shift_idle,
  output logic                  tx_shift_load,
  output logic      [7:0]       tx_shift_data,
  input  wire logic [LVL_W-1:0] rx_level,
  input  wire logic             rx_push,
  input  wire logic             char_tick,
  input  wire logic             line_err_evt,
  input  wire logic             line_status_rd,
  input  wire logic             modem_change_evt,
  input  wire logic             modem_status_rd,
  input  wire logic             irq_output_gate,
  output logic                  rx_buffer_rd,
  output logic                  receive_queue_clr,
  output logic                  transmit_queue_clr,
  output logic                  queue_mode,
  output logic      [7:0]       line_format,
  output logic      [7:0]       divisor_lo,
  output logic      [7:0]       divisor_hi,
  output logic                  serial_irq
);

  logic [7:0]       tx_holding_r, line_format_r, divisor_lo_r, divisor_hi_r, host_rdata_r;
  logic [3:0]       irq_source_enable_r, ident_r, ident_nxt;
  logic [2:0]       silent_r;
  logic [1:0]       trigger_r;
  logic             hold_full_r, tx_shift_load_r, queue_mode_r, rx_clr_r, tx_clr_r;
  logic             line_pend_r, thre_pend_r, modem_pend_r, timeout_pend_r;
  logic             rx_rd_r, irq_r, dl_sel, rda_level, any_pend;
  logic             wr_data, wr_enable, wr_queue, rd_ident, rd_buffer;

  // Trigger code to byte count
  function automatic logic [LVL_W-1:0] trig_bytes(input logic [1:0] code);
    logic [4:0] lvl;
    lvl = TRIG_LVL_0;
    if (code == 2'h1)
      lvl = TRIG_LVL_1;
    else if (code == 2'h2)
      lvl = TRIG_LVL_2;
    else if (code == 2'h3)
      lvl = TRIG_LVL_3;
    return LVL_W'(lvl);
  endfunction : trig_bytes

  // Address decode; latch select steers offsets zero and one
  assign dl_sel    = line_format_r[FMT_DLSEL_BIT];                   // see RQ23
  assign wr_data   = host_wr && (host_addr == OFS_DATA) && !dl_sel;
  assign wr_enable = host_wr && (host_addr == OFS_ENABLE) && !dl_sel;
  assign wr_queue  = host_wr && (host_addr == OFS_IDENT);             // see RQ7
  assign rd_ident  = host_rd && (host_addr == OFS_IDENT);
  assign rd_buffer = host_rd && (host_addr == OFS_DATA) && !dl_sel;

  // Holding register; the shifter takes it only when idle
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      tx_holding_r    <= 8'h00;
      hold_full_r     <= 1'b0;
      tx_shift_load_r <= 1'b0;
    end
    else
    begin
      tx_shift_load_r <= 1'b0;
      if (wr_data)
      begin
        tx_holding_r <= host_wdata;                                   // see RQ1
        hold_full_r  <= 1'b1;
      end
      else if (hold_full_r && tx_shift_idle && !tx_shift_load_r)
      begin
        hold_full_r     <= 1'b0;                                      // see RQ1
        tx_shift_load_r <= 1'b1;
      end
    end
  end

  // Enable, line format and divisor registers
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      irq_source_enable_r <= RST_ENABLE[3:0];
      line_format_r       <= RST_FORMAT;
      divisor_lo_r        <= RST_DIVISOR;
      divisor_hi_r        <= RST_DIVISOR;
    end
    else if (host_wr)
    begin
      if (wr_enable)
        irq_source_enable_r <= host_wdata[3:0];                       // see RQ2
      else if (host_addr == OFS_FORMAT)
        line_format_r <= host_wdata;
      else if (host_addr == OFS_DATA && dl_sel)
        divisor_lo_r <= host_wdata;                                   // see RQ23
      else if (host_addr == OFS_ENABLE && dl_sel)
        divisor_hi_r <= host_wdata;
    end
  end

  // Queue control; bit three and bits four, five are dropped
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      queue_mode_r <= 1'b0;
      trigger_r    <= RST_TRIGGER;
      rx_clr_r     <= 1'b0;
      tx_clr_r     <= 1'b0;
    end
    else
    begin
      rx_clr_r <= 1'b0;                                               // see RQ10
      tx_clr_r <= 1'b0;                                               // see RQ11
      if (wr_queue)                                                   // see RQ12
      begin
        queue_mode_r <= host_wdata[QC_ENABLE_BIT];                    // see RQ8
        if (!host_wdata[QC_ENABLE_BIT])
        begin
          rx_clr_r <= 1'b1;                                           // see RQ8
          tx_clr_r <= 1'b1;
        end
        else
        begin
          rx_clr_r  <= host_wdata[QC_RXCLR_BIT];                      // see RQ10
          tx_clr_r  <= host_wdata[QC_TXCLR_BIT];                      // see RQ11
          trigger_r <= host_wdata[QC_TRIG_LSB +: 2];                  // see RQ13
        end
      end
    end
  end

  // Received data level against the trigger
  assign rda_level = queue_mode_r ? (rx_level >= trig_bytes(trigger_r))  // see RQ13
                                  : (rx_level != '0);                   // see RQ22

  // Silence counter in character times
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      silent_r       <= 3'h0;
      timeout_pend_r <= 1'b0;
    end
    else
    begin
      if (rx_push || rd_buffer || rx_level == '0 || !queue_mode_r)
        silent_r <= 3'h0;
      else if (char_tick && silent_r != TIMEOUT_CHARS)
        silent_r <= silent_r + 3'h1;
      if (queue_mode_r && rx_level != '0 && char_tick
          && silent_r == TIMEOUT_CHARS - 3'h1 && !rx_push && !rd_buffer)
        timeout_pend_r <= 1'b1;                                       // see RQ20
      else if (rd_buffer || !queue_mode_r || rx_clr_r)
        timeout_pend_r <= 1'b0;                                       // see RQ20
    end
  end

  // Sticky sources; a set in the clearing cycle wins
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      line_pend_r  <= 1'b0;
      thre_pend_r  <= 1'b0;
      modem_pend_r <= 1'b0;
    end
    else
    begin
      if (line_err_evt)
        line_pend_r <= 1'b1;                                          // see RQ5
      else if (line_status_rd)
        line_pend_r <= 1'b0;                                          // see RQ22
      if (tx_shift_load_r)
        thre_pend_r <= 1'b1;                                          // see RQ4
      else if (wr_data || (rd_ident && ident_r == ID_THRE))
        thre_pend_r <= 1'b0;                                          // see RQ21
      if (modem_change_evt)
        modem_pend_r <= 1'b1;                                         // see RQ6
      else if (modem_status_rd)
        modem_pend_r <= 1'b0;                                         // see RQ22
    end
  end

  // Priority encoder over enabled sources
  always_comb
  begin
    ident_nxt = ID_NONE;                                              // see RQ16
    if (line_pend_r && irq_source_enable_r[EN_LSI_BIT])
      ident_nxt = ID_LINE;                                            // see RQ14
    else if (timeout_pend_r && irq_source_enable_r[EN_RDA_BIT])
      ident_nxt = ID_TIMEOUT;                                         // see RQ18
    else if (rda_level && irq_source_enable_r[EN_RDA_BIT])
      ident_nxt = ID_RDATA;                                           // see RQ3
    else if (thre_pend_r && irq_source_enable_r[EN_THRE_BIT])
      ident_nxt = ID_THRE;                                            // see RQ17
    else if (modem_pend_r && irq_source_enable_r[EN_MSI_BIT])
      ident_nxt = ID_MODEM;
  end

  assign any_pend = (ident_nxt != ID_NONE);

  // Identification snapshot, held while the host reads it
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      ident_r <= ID_NONE;
    else if (!rd_ident)
      ident_r <= ident_nxt;                                           // see RQ15
  end

  // Read data and receive-buffer read strobe
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      host_rdata_r <= 8'h00;
      rx_rd_r      <= 1'b0;
    end
    else
    begin
      rx_rd_r <= rd_buffer;
      if (host_rd)
      begin
        if (host_addr == OFS_IDENT)
          host_rdata_r <= {{2{queue_mode_r}}, 2'b00, ident_r};        // see RQ19
        else if (host_addr == OFS_ENABLE && !dl_sel)
          host_rdata_r <= {4'h0, irq_source_enable_r};                // see RQ2
        else if (host_addr == OFS_ENABLE)
          host_rdata_r <= divisor_hi_r;
        else if (host_addr == OFS_DATA && dl_sel)
          host_rdata_r <= divisor_lo_r;
        else if (host_addr == OFS_FORMAT)
          host_rdata_r <= line_format_r;
        else
          host_rdata_r <= 8'h00;
      end
    end
  end

  // Interrupt output through the output-two gate
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      irq_r <= 1'b0;
    else
      irq_r <= any_pend && irq_output_gate;                           // see RQ24
  end

  assign host_rdata         = host_rdata_r;
  assign tx_shift_load      = tx_shift_load_r;
  assign tx_shift_data      = tx_holding_r;
  assign rx_buffer_rd       = rx_rd_r;
  assign receive_queue_clr  = rx_clr_r;
  assign transmit_queue_clr = tx_clr_r;
  assign queue_mode         = queue_mode_r;
  assign line_format        = line_format_r;
  assign divisor_lo         = divisor_lo_r;
  assign divisor_hi         = divisor_hi_r;
  assign serial_irq         = irq_r;

  // Checks
  a_shift_waits_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)  // see RQ1
    tx_shift_load_r |-> $past(tx_shift_idle) && $past(hold_full_r))
    else $error("shifter loaded while busy or holding empty");
  a_enable_upper_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)  // see RQ2
    $past(host_rd) && $past(host_addr) == OFS_ENABLE && !$past(dl_sel)
    |-> host_rdata_r[7:4] == 4'h0)
    else $error("enable register upper bits not zero");
  a_no_irq_disabled: assert property (@(posedge ref_clk) disable iff (!reset_n)  // see RQ2
    irq_source_enable_r == 4'h0 |=> !irq_r)
    else $error("interrupt raised with all sources disabled");
  a_queue_off_clears: assert property (@(posedge ref_clk) disable iff (!reset_n)  // see RQ8
    wr_queue && !host_wdata[QC_ENABLE_BIT] |=> rx_clr_r && tx_clr_r && !queue_mode_r)
    else $error("leaving queue mode did not empty queues");
  a_clear_self_ends: assert property (@(posedge ref_clk) disable iff (!reset_n)  // see RQ10
    rx_clr_r && !$past(wr_queue) |-> 1'b0)
    else $error("receive clear held beyond one cycle");
  a_line_top: assert property (@(posedge ref_clk) disable iff (!reset_n)  // see RQ14
    line_pend_r && irq_source_enable_r[EN_LSI_BIT] && !rd_ident |=> ident_r == ID_LINE)
    else $error("line status not reported first");
  a_ident_frozen: assert property (@(posedge ref_clk) disable iff (!reset_n)  // see RQ15
    rd_ident |=> ident_r == $past(ident_r))
    else $error("identification changed during read");
  a_mode_bits: assert property (@(posedge ref_clk) disable iff (!reset_n)  // see RQ19
    $past(rd_ident) |-> host_rdata_r[7:6] == {2{$past(queue_mode_r)}})
    else $error("queue mode bits wrong");
  a_thre_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)  // see RQ21
    wr_data && !tx_shift_load_r |=> !thre_pend_r)
    else $error("holding write did not clear empty flag");
  a_gate_blocks: assert property (@(posedge ref_clk) disable iff (!reset_n)  // see RQ24
    !irq_output_gate |=> !irq_r)
    else $error("interrupt passed closed gate");

endmodule : uic_ctrl

`default_nettype wire

// ==== rtl/uic_pkg.sv ====
// Package with offsets, reset values and codes for the serial port interrupt and queue control
package uic_pkg;

  // Register offsets on the byte-wide host bus
  localparam logic [2:0] OFS_DATA       = 3'h0;  // tx_holding, divisor low when latch selected
  localparam logic [2:0] OFS_ENABLE     = 3'h1;  // irq_source_enable, divisor high when selected
  localparam logic [2:0] OFS_IDENT      = 3'h2;  // irq_identify read, queue_control write
  localparam logic [2:0] OFS_FORMAT     = 3'h3;  // line_format

  // Values after reset
  localparam logic [7:0] RST_ENABLE     = 8'h00;
  localparam logic [7:0] RST_FORMAT     = 8'h00;
  localparam logic [7:0] RST_DIVISOR    = 8'h00;
  localparam logic [1:0] RST_TRIGGER    = 2'h0;

  // Field positions
  localparam int         EN_RDA_BIT     = 0;
  localparam int         EN_THRE_BIT    = 1;
  localparam int         EN_LSI_BIT     = 2;
  localparam int         EN_MSI_BIT     = 3;
  localparam int         QC_ENABLE_BIT  = 0;
  localparam int         QC_RXCLR_BIT   = 1;
  localparam int         QC_TXCLR_BIT   = 2;
  localparam int         QC_TRIG_LSB    = 6;
  localparam int         FMT_DLSEL_BIT  = 7;

  // Identification codes in bits 3..0
  localparam logic [3:0] ID_NONE        = 4'h1;
  localparam logic [3:0] ID_LINE        = 4'h6;
  localparam logic [3:0] ID_RDATA       = 4'h4;
  localparam logic [3:0] ID_TIMEOUT     = 4'hc;
  localparam logic [3:0] ID_THRE        = 4'h2;
  localparam logic [3:0] ID_MODEM       = 4'h0;

  // Receive trigger levels in bytes
  localparam logic [4:0] TRIG_LVL_0     = 5'h01;
  localparam logic [4:0] TRIG_LVL_1     = 5'h04;
  localparam logic [4:0] TRIG_LVL_2     = 5'h08;
  localparam logic [4:0] TRIG_LVL_3     = 5'h0e;

  // Character times of silence before a receive timeout
  localparam logic [2:0] TIMEOUT_CHARS  = 3'h4;

endpackage : uic_pkg

// ==== verification/uic_shift_model.sv ====
// Transmit shifter model standing behind the holding register
`timescale 1ns/10ps
`default_nettype none

module uic_shift_model
#(
  parameter int SHIFT_CYC = 20
)
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       tx_shift_load,
  input  wire logic [7:0] tx_shift_data,
  output logic            tx_shift_idle,
  output logic      [7:0] last_byte,
  output int              load_cnt,
  output logic            bad_load
);
  int busy_r;

  // Idle only once the previous byte has fully shifted out
  assign tx_shift_idle = (busy_r == 0);

  // Take a byte, stay busy, flag any load that lands mid-shift
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      busy_r    <= 0;
      load_cnt  <= 0;
      bad_load  <= 1'b0;
      last_byte <= 8'h00;
    end
    else if (tx_shift_load)
    begin
      bad_load  <= bad_load | (busy_r != 0);
      busy_r    <= SHIFT_CYC;
      load_cnt  <= load_cnt + 1;
      last_byte <= tx_shift_data;
    end
    else if (busy_r != 0)
    begin
      busy_r <= busy_r - 1;
    end
  end
endmodule : uic_shift_model

`default_nettype wire

// ==== verification/uic_ctrl_tb.sv ====
// Self-checking bench for the serial port interrupt and queue control
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end

module uic_ctrl_tb;
  import uic_pkg::*;
  typedef struct {logic [7:0] qc; logic [4:0] lvl; logic [7:0] id;} uic_row_s;
  localparam logic [5:0] P_LERR = 6'h01;
  localparam logic [5:0] P_MCHG = 6'h02;
  localparam logic [5:0] P_LSRD = 6'h04;
  localparam logic [5:0] P_MSRD = 6'h08;
  localparam logic [5:0] P_TICK = 6'h10;
  localparam logic [5:0] P_PUSH = 6'h20;
  logic       ref_clk         = 1'b0;
  logic       reset_n         = 1'b0;
  logic [2:0] host_addr       = 3'h0;
  logic       host_wr         = 1'b0;
  logic       host_rd         = 1'b0;
  logic [7:0] host_wdata      = 8'h00;
  logic [4:0] rx_level        = 5'h00;
  logic       irq_output_gate = 1'b1;
  logic [5:0] ev              = 6'h00;
  logic [7:0] host_rdata, tx_shift_data, line_format, divisor_lo, divisor_hi;
  logic [7:0] last_byte, d;
  logic       tx_shift_idle, tx_shift_load, rx_buffer_rd, receive_queue_clr;
  logic       transmit_queue_clr, queue_mode, serial_irq, bad_load;
  int         load_cnt, r0, t0;
  int         rclr_cnt = 0;
  int         tclr_cnt = 0;
  int         bufrd_cnt = 0;
  int         error_cnt = 0;
  int         num_checks = 0;
  // Trigger rows: queue control, level, expected identification
  uic_row_s   rows[9] = '{'{8'h01, 5'h00, 8'hc1}, '{8'h01, 5'h01, 8'hc4},
    '{8'h41, 5'h03, 8'hc1}, '{8'h41, 5'h04, 8'hc4}, '{8'h81, 5'h07, 8'hc1},
    '{8'h81, 5'h08, 8'hc4}, '{8'hc1, 5'h0d, 8'hc1}, '{8'hc1, 5'h0e, 8'hc4},
    '{8'h00, 5'h01, 8'h04}};

  uic_ctrl #(.LVL_W(5)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .tx_shift_idle(tx_shift_idle), .tx_shift_load(tx_shift_load),
    .tx_shift_data(tx_shift_data), .rx_level(rx_level), .rx_push(ev[5]), .char_tick(ev[4]),
    .line_err_evt(ev[0]), .line_status_rd(ev[2]), .modem_change_evt(ev[1]),
    .modem_status_rd(ev[3]), .irq_output_gate(irq_output_gate), .rx_buffer_rd(rx_buffer_rd),
    .receive_queue_clr(receive_queue_clr), .transmit_queue_clr(transmit_queue_clr),
    .queue_mode(queue_mode), .line_format(line_format), .divisor_lo(divisor_lo),
    .divisor_hi(divisor_hi), .serial_irq(serial_irq));

  uic_shift_model #(.SHIFT_CYC(20)) i_shift (.ref_clk(ref_clk), .reset_n(reset_n),
    .tx_shift_load(tx_shift_load), .tx_shift_data(tx_shift_data),
    .tx_shift_idle(tx_shift_idle), .last_byte(last_byte), .load_cnt(load_cnt),
    .bad_load(bad_load));

  // Clock
  always #5 ref_clk = ~ref_clk;

  // Count one-cycle pulses so they are never missed
  always @(posedge ref_clk)
  begin
    rclr_cnt  <= rclr_cnt + int'(receive_queue_clr);
    tclr_cnt  <= tclr_cnt + int'(transmit_queue_clr);
    bufrd_cnt <= bufrd_cnt + int'(rx_buffer_rd);
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    host_addr  <= a;
    host_wdata <= v;
    host_wr    <= 1'b1;
    @(posedge ref_clk);
    host_wr <= 1'b0;
  endtask : wr

  // Read with the strobe held n cycles; data holds until the next read
  task automatic rd(input logic [2:0] a, input int n = 1);
    @(posedge ref_clk);
    host_addr <= a;
    host_rd   <= 1'b1;
    repeat (n) @(posedge ref_clk);
    host_rd <= 1'b0;
    @(posedge ref_clk);
    d = host_rdata; // Settled one edge ago, so stimulus stays on the edge
  endtask : rd

  task automatic pulse(input logic [5:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 6'h00;
  endtask : pulse

  task automatic wait_load(input int n);
    for (int i = 0; i < 200 && load_cnt < n; i++)
      @(posedge ref_clk);
    if (load_cnt < n)
    begin
      error_cnt++;
      $display("mismatch at %0t: no shifter load", $time);
      tally_and_finish();
    end
  endtask : wait_load

  // Main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(OFS_ENABLE);
    `CHK(d, RST_ENABLE)
    `CHK(line_format, RST_FORMAT)
    rd(OFS_IDENT);
    `CHK(d, {4'h0, ID_NONE})
    `CHK(serial_irq, 1'b0)
    $display("test reset done");
    wr(OFS_ENABLE, 8'h01);
    foreach (rows[i])
    begin
      wr(OFS_IDENT, rows[i].qc);
      @(posedge ref_clk);
      rx_level <= rows[i].lvl;
      rd(OFS_IDENT);
      `CHK(d, rows[i].id)
      `CHK(serial_irq, ~rows[i].id[0])
    end
    rx_level <= 5'h00;
    $display("test trigger rows done");
    wr(OFS_ENABLE, 8'hff);
    rd(OFS_ENABLE);
    `CHK(d, 8'h0f)
    r0 = rclr_cnt;
    t0 = tclr_cnt;
    wr(OFS_IDENT, 8'h07);
    wr(OFS_IDENT, 8'h09);
    repeat (2) @(posedge ref_clk);
    `CHK(rclr_cnt - r0, 1)
    `CHK(tclr_cnt - t0, 1)
    wr(OFS_IDENT, 8'h03);
    wr(OFS_IDENT, 8'h00);
    repeat (2) @(posedge ref_clk);
    `CHK(rclr_cnt - r0, 3)
    `CHK(tclr_cnt - t0, 2)
    `CHK(queue_mode, 1'b0)
    rd(OFS_IDENT);
    `CHK(d, 8'h01)
    $display("test queue clear done");
    wr(OFS_FORMAT, 8'h80);
    wr(OFS_DATA, 8'h5a);
    wr(OFS_ENABLE, 8'ha5);
    rd(OFS_ENABLE);
    `CHK(d, 8'ha5)
    `CHK({divisor_hi, divisor_lo}, 16'ha55a)
    wr(OFS_FORMAT, 8'h03);
    @(posedge ref_clk);
    `CHK(line_format, 8'h03)
    rd(OFS_ENABLE);
    `CHK(d, 8'h0f)
    `CHK(load_cnt, 0)
    $display("test divisor done");
    wr(OFS_DATA, 8'h3c);
    wr(OFS_DATA, 8'hc3);
    wait_load(2);
    `CHK(last_byte, 8'hc3)
    rd(OFS_IDENT);
    `CHK(d, {4'h0, ID_THRE})
    rd(OFS_IDENT);
    `CHK(d, 8'h01)
    wr(OFS_DATA, 8'h11);
    wait_load(3);
    `CHK(last_byte, 8'h11)
    @(posedge ref_clk);
    `CHK(serial_irq, 1'b1)
    wr(OFS_DATA, 8'h22);
    rd(OFS_IDENT);
    `CHK(d, 8'h01)
    `CHK(bad_load, 1'b0)
    $display("test holding done");
    wait_load(4);
    `CHK(last_byte, 8'h22)
    pulse(P_LERR);
    pulse(P_MCHG);
    rx_level <= 5'h01;
    rd(OFS_IDENT);
    `CHK(d, {4'h0, ID_LINE})
    pulse(P_LSRD);
    rd(OFS_IDENT);
    `CHK(d, {4'h0, ID_RDATA})
    rx_level <= 5'h00;
    rd(OFS_IDENT);
    `CHK(d, 8'h02)
    rd(OFS_IDENT);
    `CHK(d, {4'h0, ID_MODEM})
    irq_output_gate <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(serial_irq, 1'b0)
    irq_output_gate <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK(serial_irq, 1'b1)
    wr(OFS_ENABLE, 8'h07);
    rd(OFS_IDENT);
    `CHK(d, 8'h01)
    `CHK(serial_irq, 1'b0)
    wr(OFS_ENABLE, 8'h0f);
    pulse(P_MSRD);
    rd(OFS_IDENT);
    `CHK(d, 8'h01)
    $display("test priority done");
    pulse(P_MCHG);
    fork
      rd(OFS_IDENT, 6);
      begin
        repeat (2) @(posedge ref_clk);
        pulse(P_LERR);
      end
    join
    `CHK(d, 8'h00)
    rd(OFS_IDENT);
    `CHK(d, 8'h06)
    pulse(P_LSRD);
    pulse(P_MSRD);
    $display("test freeze done");
    wr(OFS_IDENT, 8'hc1);
    rx_level <= 5'h01;
    repeat (3) pulse(P_TICK);
    pulse(P_PUSH);
    repeat (3) pulse(P_TICK);
    rd(OFS_IDENT);
    `CHK(d, 8'hc1)
    pulse(P_TICK);
    rd(OFS_IDENT);
    `CHK(d, {4'hc, ID_TIMEOUT})
    `CHK(serial_irq, 1'b1)
    r0 = bufrd_cnt;
    rd(OFS_DATA);
    rd(OFS_IDENT);
    `CHK(d, 8'hc1)
    `CHK(bufrd_cnt - r0, 1)
    $display("test timeout done");
    // Reset in mid-run with queue mode, enables and divisor all set
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(OFS_IDENT);
    `CHK(d, {4'h0, ID_NONE})
    `CHK(queue_mode, 1'b0)
    `CHK(line_format, RST_FORMAT)
    `CHK({divisor_hi, divisor_lo}, {RST_DIVISOR, RST_DIVISOR})
    rd(OFS_ENABLE);
    `CHK(d, RST_ENABLE)
    `CHK(serial_irq, 1'b0)
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule : uic_ctrl_tb

`default_nettype wire
